// *** verilog/sram_wr_defines.svh ***
// constants for the byte-write decode and data pin control
`ifndef SRAM_WR_DEFINES_SVH
`define SRAM_WR_DEFINES_SVH
`define LANE_COUNT 4
`define LANE_WIDTH 8
`define DATA_WIDTH 32
`define ADDR_WIDTH 17
`define DEPTH 131072
`define LANE_A 0
`define LANE_B 1
`define LANE_C 2
`define LANE_D 3
`define LANES_NONE 4'h0
`define LANES_ALL 4'hf
`endif

// *** verilog/sram_wr_pkg.sv ***
// types shared by the byte-write decode and the memory core
package sram_wr_pkg;
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_READ,
    CYC_WRITE
  } cycle_t;

  typedef struct packed {
    logic global_write_n;
    logic byte_write_gate_n;
    logic lane_d_write_n;
    logic lane_c_write_n;
    logic lane_b_write_n;
    logic lane_a_write_n;
  } write_ctl_t;

  typedef struct packed {
    logic chip_enable_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
  } strobe_t;

  typedef struct packed {
    logic [16:0] addr;
    logic [3:0] lanes;
    logic [31:0] data;
  } write_req_t;
endpackage

// *** verilog/sram_lane_array.sv ***
// byte-lane memory array with per-lane write
`timescale 1ns/1ps
`include "sram_wr_defines.svh"
module sram_lane_array (
  // clock
  input wire logic clock,
  // write port
  input wire logic wr_valid,
  input sram_wr_pkg::write_req_t wr_req,
  // read port
  input wire logic [`ADDR_WIDTH-1:0] rd_addr,
  output logic [`DATA_WIDTH-1:0] rd_data
);
  import sram_wr_pkg::*;

  logic [`DATA_WIDTH-1:0] mem [0:`DEPTH-1];

  // only lanes marked in the request change
  always_ff @(posedge clock) begin
    if (wr_valid) begin
      for (int i = 0; i < `LANE_COUNT; i++) begin
        if (wr_req.lanes[i]) begin
          mem[wr_req.addr][i*`LANE_WIDTH +: `LANE_WIDTH] <=
            wr_req.data[i*`LANE_WIDTH +: `LANE_WIDTH];
        end
      end
    end
  end

  // registered read, no reset on array output path
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule // sram_lane_array

// *** verilog/sync_sram_byte_write_decode.sv ***
// write decode, cycle start and data pin control of the sync sram
`timescale 1ns/1ps
`include "sram_wr_defines.svh"
module sync_sram_byte_write_decode (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // address and strobes
  input wire logic [`ADDR_WIDTH-1:0] ADDR,
  input sram_wr_pkg::strobe_t STROBE,
  // write controls
  input sram_wr_pkg::write_ctl_t WRITE_CTL,
  // asynchronous output enable
  input wire logic OUTPUT_ENABLE_N,
  // data pins, split in lanes a..d from low byte up
  input wire logic [`DATA_WIDTH-1:0] DATA_IN,
  output logic [`DATA_WIDTH-1:0] DATA_OUT,
  output logic [`LANE_COUNT-1:0] DATA_OE,
  // status
  output sram_wr_pkg::cycle_t CYCLE
);
  import sram_wr_pkg::*;

  // lane vector of a write; zero means read
  function automatic logic [`LANE_COUNT-1:0] lane_mask(input write_ctl_t c);
    logic [`LANE_COUNT-1:0] lanes;
    lanes = `LANES_NONE;
    if (!c.global_write_n) begin
      lanes = `LANES_ALL;
    end else if (!c.byte_write_gate_n) begin
      lanes[`LANE_A] = !c.lane_a_write_n;
      lanes[`LANE_B] = !c.lane_b_write_n;
      lanes[`LANE_C] = !c.lane_c_write_n;
      lanes[`LANE_D] = !c.lane_d_write_n;
    end
    return lanes;
  endfunction

  // address strobe decodes, shared by the cycle logic and the write capture
  function automatic logic proc_start(input strobe_t s);
    return !s.processor_addr_strobe_n && !s.chip_enable_n;
  endfunction

  function automatic logic ctrl_start(input strobe_t s);
    return s.processor_addr_strobe_n && !s.controller_addr_strobe_n && !s.chip_enable_n;
  endfunction

  // both strobes high: a follow-on clock of the cycle in progress
  function automatic logic strobes_idle(input strobe_t s);
    return s.processor_addr_strobe_n && s.controller_addr_strobe_n;
  endfunction

  function automatic cycle_t pick_cycle(input logic wr);
    return wr ? CYC_WRITE : CYC_READ;
  endfunction

  // bytes of a just-issued write win over the array word read beside them
  function automatic logic [`DATA_WIDTH-1:0] merge_lanes(
    input logic [`DATA_WIDTH-1:0] old_word,
    input logic [`DATA_WIDTH-1:0] new_word,
    input logic [`LANE_COUNT-1:0] lanes
  );
    logic [`DATA_WIDTH-1:0] word;
    word = old_word;
    for (int i = 0; i < `LANE_COUNT; i++) begin
      if (lanes[i]) begin
        word[i*`LANE_WIDTH +: `LANE_WIDTH] = new_word[i*`LANE_WIDTH +: `LANE_WIDTH];
      end
    end
    return word;
  endfunction

  // pins drive only in a read with the enable low; writes mask the enable
  function automatic logic [`LANE_COUNT-1:0] pin_drive(input cycle_t c, input logic oe_n);
    logic [`LANE_COUNT-1:0] drive;
    drive = `LANES_NONE;
    case (c)
      CYC_READ: drive = oe_n ? `LANES_NONE : `LANES_ALL;
      CYC_WRITE: drive = `LANES_NONE;
      default: drive = `LANES_NONE;
    endcase
    return drive;
  endfunction

  logic [`LANE_COUNT-1:0] next_lanes;
  logic write_ind;
  logic start_proc;
  logic start_ctrl;
  logic continue_cyc;
  logic wr_valid;
  write_req_t wr_req;
  logic [`ADDR_WIDTH-1:0] addr_reg;
  logic [`ADDR_WIDTH-1:0] rd_addr;
  logic [`DATA_WIDTH-1:0] rd_data;
  cycle_t cycle;
  cycle_t next_cycle;
  logic deselect;
  logic [`LANE_COUNT-1:0] fwd_lanes;
  logic [`DATA_WIDTH-1:0] fwd_data;

  assign next_lanes = lane_mask(WRITE_CTL);
  assign write_ind = |next_lanes;
  // processor strobe wins: it never starts a write
  assign start_proc = proc_start(STROBE);
  assign start_ctrl = ctrl_start(STROBE);
  // follow-on clocks reuse the held address; relies on the master's ordering
  assign continue_cyc = strobes_idle(STROBE) && (cycle != CYC_IDLE);
  // a strobe seen with the chip disabled deselects
  assign deselect = !strobes_idle(STROBE) && STROBE.chip_enable_n;

  // idle never continues; a processor strobe always reads
  always_comb begin
    next_cycle = cycle;
    case (cycle)
      CYC_IDLE: begin
        if (start_proc) begin
          next_cycle = CYC_READ;
        end else if (start_ctrl) begin
          next_cycle = pick_cycle(write_ind);
        end
      end
      CYC_READ, CYC_WRITE: begin
        if (start_proc) begin
          next_cycle = CYC_READ;
        end else if (start_ctrl || continue_cyc) begin
          next_cycle = pick_cycle(write_ind);
        end else if (deselect) begin
          next_cycle = CYC_IDLE;
        end
      end
      default: begin
        next_cycle = CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cycle <= CYC_IDLE;
    end else begin
      cycle <= next_cycle;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      addr_reg <= '0;
    end else if (start_proc || start_ctrl) begin
      addr_reg <= ADDR;
    end
  end

  // a write that the strobes start or continue lands one edge later
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_valid <= 1'b0;
    end else begin
      wr_valid <= !start_proc && (start_ctrl || continue_cyc) && write_ind;
    end
  end

  // write data, lanes and address taken on the command edge
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_req <= '0;
    end else begin
      wr_req.addr <= start_ctrl ? ADDR : addr_reg;
      wr_req.lanes <= next_lanes;
      wr_req.data <= DATA_IN;
    end
  end

  assign rd_addr = (start_proc || start_ctrl) ? ADDR : addr_reg;

  sram_lane_array sram_lane_array_inst (
    .clock(CLOCK),
    .wr_valid(wr_valid),
    .wr_req(wr_req),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // array is updated one edge late, so a read right behind a write takes its bytes here
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fwd_lanes <= `LANES_NONE;
    end else if (wr_valid && (wr_req.addr == rd_addr)) begin
      fwd_lanes <= wr_req.lanes;
    end else begin
      fwd_lanes <= `LANES_NONE;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fwd_data <= '0;
    end else begin
      fwd_data <= wr_req.data;
    end
  end

  // pipelined output stage: read data appears the edge after the array read
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      DATA_OUT <= '0;
    end else begin
      DATA_OUT <= merge_lanes(rd_data, fwd_data, fwd_lanes);
    end
  end

  // unclocked enable; write cycles mask it so the master can leave it anywhere
  always_comb begin
    DATA_OE = pin_drive(cycle, OUTPUT_ENABLE_N);
  end

  assign CYCLE = cycle;
endmodule // sync_sram_byte_write_decode

// *** testbench/sram_chk.sv ***
// port assertions for the sync sram write decode
`timescale 1ns/1ps
module sram_chk (
  // watched ports
  input wire logic CLOCK,
  input wire logic RST_N,
  input sram_wr_pkg::strobe_t STROBE,
  input sram_wr_pkg::write_ctl_t WRITE_CTL,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [3:0] DATA_OE,
  input sram_wr_pkg::cycle_t CYCLE
);
  import sram_wr_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire ce = !STROBE.chip_enable_n;
  wire ctl = ce && STROBE.processor_addr_strobe_n && !STROBE.controller_addr_strobe_n;
  wire gw = !WRITE_CTL.global_write_n;
  wire bw = !WRITE_CTL.byte_write_gate_n && WRITE_CTL[3:0] != 4'hf;
  wire fol = &STROBE[1:0] && CYCLE != CYC_IDLE;
  sequence wr_cmd;
    ctl && (gw || bw);
  endsequence
  sequence rd_cmd;
    ctl && !gw && !bw;
  endsequence
  a_write_decode: assert property (wr_cmd |=> CYCLE == CYC_WRITE)
    else $error("write not started");
  a_read_decode: assert property (rd_cmd |=> CYCLE == CYC_READ)
    else $error("read not started");
  a_global_write: assert property (ctl && gw |=> CYCLE == CYC_WRITE)
    else $error("global write lost");
  a_proc_read: assert property (ce && !STROBE[1] |=> CYCLE == CYC_READ)
    else $error("processor strobe not read");
  a_write_mask: assert property (CYCLE == CYC_WRITE |-> DATA_OE == 4'h0)
    else $error("pins driven in write");
  a_read_drive: assert property (CYCLE == CYC_READ |-> DATA_OE == {4{!OUTPUT_ENABLE_N}})
    else $error("read drive wrong");
  a_idle_float: assert property (CYCLE == CYC_IDLE |-> DATA_OE == 4'h0)
    else $error("pins driven when idle");
  a_deselect_idle: assert property (!ce && !(&STROBE[1:0]) |=> CYCLE == CYC_IDLE)
    else $error("deselect not idle");
  a_follow_write: assert property (fol && (gw || bw) |=> CYCLE == CYC_WRITE)
    else $error("follow-on write lost");
  a_follow_read: assert property (fol && !gw && !bw |=> CYCLE == CYC_READ)
    else $error("follow-on read lost");
endmodule // sram_chk
bind sync_sram_byte_write_decode sram_chk sram_chk_inst (.CLOCK(CLOCK), .RST_N(RST_N),
  .STROBE(STROBE), .WRITE_CTL(WRITE_CTL), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .DATA_OE(DATA_OE), .CYCLE(CYCLE));

// *** testbench/bus_master_model.sv ***
// bus master model: output enable around cycles
`timescale 1ns/1ps
module bus_master_model (
  // from bench
  input wire logic want_read,
  // to memory
  output logic oe_n
);
  // oe high ahead of every write so pins release
  assign oe_n = !want_read;
endmodule // bus_master_model

// *** testbench/sync_sram_byte_write_decode_test.sv ***
// self-checking bench for the sync sram write decode
`timescale 1ns/1ps
module sync_sram_byte_write_decode_test;
  import sram_wr_pkg::*;
  logic clock = 0, rst_n = 0, want_read = 0, oe_n, g;
  logic [16:0] addr = 0;
  strobe_t strobe = 3'h6;
  write_ctl_t wctl = 6'h3f;
  logic [31:0] data_in = 0, data_out, seed = 63, word;
  logic [3:0] data_oe, m;
  cycle_t cycle;
  int failures = 0, check_count = 0;
  always #50 clock = !clock;
  bus_master_model bus_master_model_inst (.want_read(want_read), .oe_n(oe_n));
  sync_sram_byte_write_decode sync_sram_byte_write_decode_inst (.CLOCK(clock),
    .RST_N(rst_n), .ADDR(addr), .STROBE(strobe), .WRITE_CTL(wctl),
    .OUTPUT_ENABLE_N(oe_n), .DATA_IN(data_in), .DATA_OUT(data_out),
    .DATA_OE(data_oe), .CYCLE(cycle));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] k);
    for (int i = 0; i < 4; i++) if (k[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, seen);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one command from this falling edge; back to back with the next call
  task automatic op(input logic [2:0] s, input logic [5:0] w, input cycle_t exp);
    strobe <= s;
    wctl <= w;
    want_read <= exp == CYC_READ;
    seed = xs(seed);
    data_in <= seed;
    @(negedge clock);
    chk("cycle", 32'(exp), 32'(cycle));
    chk("oe", 32'((exp == CYC_READ) ? 4'hf : 4'h0), 32'(data_oe));
  endtask
  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock) rst_n <= 1;
    for (int i = 0; i < 24; i++) begin
      g = i >= 16;
      m = g ? seed[3:0] : 4'(i);
      addr <= seed[16:0];
      op(3'h2, {1'b0, seed[4:0]}, CYC_WRITE);
      word = data_in;
      op(3'h2, {1'b1, g, ~m}, (g || m == 0) ? CYC_READ : CYC_WRITE);
      word = merge(word, data_in, g ? 4'h0 : m);
      // read right behind the write, then a follow-on write on the held address
      op(3'h0, {1'b0, seed[4:0]}, CYC_READ);
      op(3'h7, {1'b0, seed[4:0]}, CYC_WRITE);
      chk("data", word, data_out);
      word = data_in;
      op(3'h0, {1'b1, 1'b1, ~m}, CYC_READ);
      strobe <= 3'h6;
      want_read <= seed[0];
      @(negedge clock);
      chk("follow data", word, data_out);
      chk("idle", 32'(CYC_IDLE), 32'(cycle));
    end
    summarize();
  end
  // the sequence needs about 164 cycles
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule // sync_sram_byte_write_decode_test
